// *** inc/fvsb_pkg.sv ***
// Package with constants and types for the volatile status byte block
package fvsb_pkg;

  // Byte offsets
  localparam logic [7:0] OFS_CFG_LAST   = 8'h0b;
  localparam logic [7:0] OFS_STATUS     = 8'h0c;
  localparam logic [7:0] OFS_FCA_LOW    = 8'h0d;
  localparam logic [7:0] OFS_FCA_MLOW   = 8'h0e;
  localparam logic [7:0] OFS_FCA_MHIGH  = 8'h0f;
  localparam logic [7:0] OFS_FCA_HIGH   = 8'h10;
  localparam logic [7:0] OFS_BANK       = 8'h11;
  localparam int         CFG_BYTES      = 12;

  // Field positions in byte 0Bh
  localparam int CFG_ECC_OFF_BIT   = 0;
  localparam int CFG_SEL_DBL_BIT   = 2;
  localparam int CFG_CHK_OFF_BIT   = 3;

  // Field positions in byte 0Ch
  localparam int ST_REPEAT_BIT     = 7;
  localparam int ST_TALLY_MSB      = 6;
  localparam int ST_TALLY_LSB      = 3;
  localparam int ST_DOUBLE_BIT     = 2;
  localparam int ST_PARITY_BIT     = 1;
  localparam int ST_CRC_BIT        = 0;
  localparam logic [3:0] TALLY_MAX = 4'hf;

  // Reset values
  localparam logic [7:0]  RESERVED_BYTE = 8'hff;
  localparam logic [7:0]  STATUS_RST    = 8'h00;
  localparam logic [27:0] FCA_RST       = 28'hfffffff;
  localparam logic [3:0]  FCA_LOW_NIB   = 4'h0;
  localparam logic [4:0]  BANK_RSV_BITS = 5'h1f;
  localparam logic [2:0]  BANK_IDLE     = 3'h0;

  // Link command codes and field lengths
  localparam logic [7:0] CMD_RD_VOL    = 8'h85;
  localparam logic [7:0] CMD_WR_VOL    = 8'h81;
  localparam int         ADDR_BITS     = 32;
  localparam int         BYTE_BITS     = 8;

  // Events from the array and correction engine
  typedef struct packed {
    logic        correction;
    logic        double_err;
    logic        parity_err;
    logic        crc_err;
    logic        repeat_prog;
    logic [31:0] addr;
  } ecc_events_t;

  // Link pins after synchronisation
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic dq;
  } link_pins_t;

endpackage : fvsb_pkg

// *** design/sync2.sv ***
// Two flip-flop synchroniser for pin inputs
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // Two stages; first stage feeds only the second
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= '1;
      s2_q <= '1;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;

endmodule : sync2

// *** design/status_tracker.sv ***
// Sticky error flags, correction tally and first event address
module status_tracker (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Events and configuration
  input  fvsb_pkg::ecc_events_t    ev,
  input  wire logic [7:0]          cfg_0b,
  input  wire logic                octal_ddr,
  // Status
  output logic      [7:0]          status_q,
  output logic      [27:0]         fca_q
);

  logic [7:0]  status_d;
  logic [27:0] fca_d;
  logic        captured_q;
  logic        captured_d;
  logic        ecc_on;
  logic        chk_on;
  logic        pick;
  logic [3:0]  tally;

  // Configuration decode
  assign ecc_on = ~cfg_0b[fvsb_pkg::CFG_ECC_OFF_BIT];
  assign chk_on = ~cfg_0b[fvsb_pkg::CFG_CHK_OFF_BIT] & octal_ddr;
  assign pick   = cfg_0b[fvsb_pkg::CFG_SEL_DBL_BIT] ? ev.double_err : ev.correction;
  assign tally  = status_q[fvsb_pkg::ST_TALLY_MSB:fvsb_pkg::ST_TALLY_LSB];

  // Next status; flags only ever set
  always_comb
  begin
    status_d   = status_q;
    fca_d      = fca_q;
    captured_d = captured_q;
    if (ecc_on && ev.repeat_prog)
      status_d[fvsb_pkg::ST_REPEAT_BIT] = 1'b1;
    if (ecc_on && ev.correction && tally != fvsb_pkg::TALLY_MAX)
      status_d[fvsb_pkg::ST_TALLY_MSB:fvsb_pkg::ST_TALLY_LSB] = tally + 4'h1;
    if (ecc_on && ev.double_err)
      status_d[fvsb_pkg::ST_DOUBLE_BIT] = 1'b1;
    if (chk_on && ev.parity_err)
      status_d[fvsb_pkg::ST_PARITY_BIT] = 1'b1;
    if (chk_on && ev.crc_err)
      status_d[fvsb_pkg::ST_CRC_BIT] = 1'b1;
    if (ecc_on && pick && !captured_q)
    begin
      fca_d      = ev.addr[31:4];
      captured_d = 1'b1;
    end
  end

  // Status registers, cleared only by reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_q   <= fvsb_pkg::STATUS_RST;
      fca_q      <= fvsb_pkg::FCA_RST;
      captured_q <= 1'b0;
    end
    else
    begin
      status_q   <= status_d;
      fca_q      <= fca_d;
      captured_q <= captured_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Tally holds at its ceiling
  AST_TALLY_SAT: assert property (tally == 4'hf |=> tally == 4'hf)
    else $error("correction tally left saturation");
  // Tally steps by one on a correction with correction on
  AST_TALLY_INC: assert property (ecc_on && ev.correction && tally != 4'hf
    |=> tally == $past(tally) + 4'h1)
    else $error("correction tally did not step");
  // Double error flag is sticky
  AST_DBL_STICKY: assert property (status_q[2] |=> status_q[2][*8])
    else $error("double error flag dropped");
  // Parity flag ignores events while checks are off
  AST_PAR_GATED: assert property (!chk_on && !status_q[1] |=> !status_q[1])
    else $error("parity flag set with checks off");
  // CRC flag rises on an enabled CRC event
  AST_CRC_SET: assert property (chk_on && ev.crc_err |=> status_q[0])
    else $error("crc flag not set");
  // First address is frozen once captured
  AST_FCA_FIRST: assert property (captured_q |=> $stable(fca_q))
    else $error("first event address overwritten");
  // Capture follows the selected event kind
  AST_FCA_SEL: assert property (ecc_on && pick && !captured_q
    |=> fca_q == $past(ev.addr[31:4]))
    else $error("first event address not captured");

endmodule : status_tracker

// *** design/flash_volatile_status_bytes.sv ***
// Volatile register space link decoder with status bytes 0Ch to 11h
module flash_volatile_status_bytes (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Serial link pins
  input  wire logic                 cs_n_i,
  input  wire logic                 sck_i,
  input  wire logic                 dq_i,
  output logic                      dq_o_q,
  output logic                      dq_oe_q,
  // Configuration bytes 00h..0Bh
  input  wire logic [95:0]          cfg_bytes,
  output logic                      cfg_wr_q,
  output logic      [7:0]           cfg_addr_q,
  output logic      [7:0]           cfg_data_q,
  // Array engine events and operation state
  input  fvsb_pkg::ecc_events_t     ev,
  input  wire logic                 octal_ddr,
  input  wire logic                 pe_active,
  input  wire logic [1:0]           pe_bank,
  // Flag status and write enable side effects
  output logic                      fsr_err_set_q,
  output logic                      wel_clear_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and declarations

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_CMD   = 7'b0000010,
    ST_ADDR  = 7'b0000100,
    ST_WDATA = 7'b0001000,
    ST_RLOAD = 7'b0010000,
    ST_RDATA = 7'b0100000,
    ST_DONE  = 7'b1000000
  } link_state_t;

  link_state_t          state_q;
  link_state_t          state_d;
  fvsb_pkg::link_pins_t pins_s;
  fvsb_pkg::link_pins_t pins_raw;
  logic                 sck_prev_q;
  logic                 rise;
  logic                 fall;
  logic [4:0]           cnt_q;
  logic [4:0]           cnt_d;
  logic [7:0]           sin_q;
  logic [7:0]           sin_d;
  logic [7:0]           byte_in;
  logic                 is_wr_q;
  logic                 is_wr_d;
  logic [7:0]           addr_d;
  logic [7:0]           addr_nx;
  logic [7:0]           sout_q;
  logic [7:0]           sout_d;
  logic                 dq_d;
  logic                 oe_d;
  logic                 cfg_wr_d;
  logic [7:0]           cfg_data_d;
  logic                 ferr_d;
  logic                 wclr_d;
  logic [2:0]           bank_q;
  logic [2:0]           bank_d;
  logic [7:0]           status;
  logic [27:0]          fca;
  logic [7:0]           rd_now;
  logic [7:0]           rd_next;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and clock edges

  assign pins_raw = '{cs_n: cs_n_i, sck: sck_i, dq: dq_i};

  sync2 #(.W(3)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (pins_raw),
    .q    (pins_s)
  );

  assign rise    = pins_s.sck & ~sck_prev_q;
  assign fall    = ~pins_s.sck & sck_prev_q;
  assign byte_in = {sin_q[6:0], pins_s.dq};
  assign addr_nx = addr_q_inc(cfg_addr_q);

  ////////////////////////////////////////////////////////////////////////////
  // Status byte tracker

  status_tracker u_status (
    .clk       (clk),
    .nrst      (nrst),
    .ev        (ev),
    .cfg_0b    (cfg_bytes[8*fvsb_pkg::CFG_BYTES-1 -: 8]),
    .octal_ddr (octal_ddr),
    .status_q  (status),
    .fca_q     (fca)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and helpers

  function automatic logic [7:0] addr_q_inc(input logic [7:0] a);
    addr_q_inc = 8'(a + 8'h01);
  endfunction : addr_q_inc

  // Byte returned for one register location
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] r;
    r = fvsb_pkg::RESERVED_BYTE;
    if (a <= fvsb_pkg::OFS_CFG_LAST)
      r = cfg_bytes[8*a +: 8];
    else
    begin
      case (a)
        fvsb_pkg::OFS_STATUS:    r = status;
        fvsb_pkg::OFS_FCA_LOW:   r = {fca[3:0], fvsb_pkg::FCA_LOW_NIB};
        fvsb_pkg::OFS_FCA_MLOW:  r = fca[11:4];
        fvsb_pkg::OFS_FCA_MHIGH: r = fca[19:12];
        fvsb_pkg::OFS_FCA_HIGH:  r = fca[27:20];
        fvsb_pkg::OFS_BANK:      r = {fvsb_pkg::BANK_RSV_BITS, bank_q};
        default:                 r = fvsb_pkg::RESERVED_BYTE;
      endcase
    end
    read_byte = r;
  endfunction : read_byte

  // Bytes at the current and next address; process form follows every source byte
  always_comb
  begin
    rd_now  = read_byte(cfg_addr_q);
    rd_next = read_byte(addr_nx);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy bank code

  always_comb
  begin
    bank_d = pe_active ? {1'b1, pe_bank} : fvsb_pkg::BANK_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link command state machine

  always_comb
  begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    sin_d      = sin_q;
    is_wr_d    = is_wr_q;
    addr_d     = cfg_addr_q;
    sout_d     = sout_q;
    dq_d       = dq_o_q;
    oe_d       = dq_oe_q;
    cfg_wr_d   = 1'b0;
    cfg_data_d = cfg_data_q;
    ferr_d     = 1'b0;
    wclr_d     = 1'b0;
    if (pins_s.cs_n)
    begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
      dq_d    = 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          state_d = ST_CMD;
          cnt_d   = 5'h00;
        end
        ST_CMD:
          if (rise)
          begin
            sin_d = byte_in;
            cnt_d = 5'(cnt_q + 5'h01);
            if (cnt_q == 5'(fvsb_pkg::BYTE_BITS - 1))
            begin
              cnt_d   = 5'h00;
              is_wr_d = (byte_in == fvsb_pkg::CMD_WR_VOL);
              if (byte_in == fvsb_pkg::CMD_WR_VOL || byte_in == fvsb_pkg::CMD_RD_VOL)
                state_d = ST_ADDR;
              else
                state_d = ST_DONE;
            end
          end
        ST_ADDR:
          if (rise)
          begin
            sin_d = byte_in;
            cnt_d = 5'(cnt_q + 5'h01);
            if (cnt_q == 5'(fvsb_pkg::ADDR_BITS - 1))
            begin
              cnt_d   = 5'h00;
              addr_d  = byte_in;
              state_d = is_wr_q ? ST_WDATA : ST_RLOAD;
            end
          end
        ST_WDATA:
          if (rise)
          begin
            sin_d = byte_in;
            cnt_d = 5'(cnt_q + 5'h01);
            if (cnt_q == 5'(fvsb_pkg::BYTE_BITS - 1))
            begin
              state_d    = ST_DONE;
              cfg_data_d = byte_in;
              if (cfg_addr_q <= fvsb_pkg::OFS_CFG_LAST)
                cfg_wr_d = 1'b1;
              else if (cfg_addr_q > fvsb_pkg::OFS_BANK)
              begin
                ferr_d = 1'b1;
                wclr_d = 1'b1;
              end
              // Status bytes take no write at all
            end
          end
        ST_RLOAD:
          if (fall)
          begin
            sout_d  = rd_now;
            dq_d    = rd_now[7];
            oe_d    = 1'b1;
            cnt_d   = 5'h00;
            state_d = ST_RDATA;
          end
        ST_RDATA:
          if (fall)
          begin
            if (cnt_q == 5'(fvsb_pkg::BYTE_BITS - 1))
            begin
              addr_d = addr_nx;
              sout_d = rd_next;
              dq_d   = rd_next[7];
              cnt_d  = 5'h00;
            end
            else
            begin
              sout_d = {sout_q[6:0], 1'b0};
              dq_d   = sout_q[6];
              cnt_d  = 5'(cnt_q + 5'h01);
            end
          end
        ST_DONE:
          state_d = ST_DONE;
        default:
          state_d = ST_IDLE;
      endcase
    end
  end

  // Link registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q       <= ST_IDLE;
      sck_prev_q    <= 1'b1;
      cnt_q         <= 5'h00;
      sin_q         <= 8'h00;
      is_wr_q       <= 1'b0;
      cfg_addr_q    <= fvsb_pkg::RESERVED_BYTE;
      sout_q        <= fvsb_pkg::RESERVED_BYTE;
      dq_o_q        <= 1'b0;
      dq_oe_q       <= 1'b0;
      cfg_wr_q      <= 1'b0;
      cfg_data_q    <= fvsb_pkg::RESERVED_BYTE;
      fsr_err_set_q <= 1'b0;
      wel_clear_q   <= 1'b0;
      bank_q        <= fvsb_pkg::BANK_IDLE;
    end
    else
    begin
      state_q       <= state_d;
      sck_prev_q    <= pins_s.sck;
      cnt_q         <= cnt_d;
      sin_q         <= sin_d;
      is_wr_q       <= is_wr_d;
      cfg_addr_q    <= addr_d;
      sout_q        <= sout_d;
      dq_o_q        <= dq_d;
      dq_oe_q       <= oe_d;
      cfg_wr_q      <= cfg_wr_d;
      cfg_data_q    <= cfg_data_d;
      fsr_err_set_q <= ferr_d;
      wel_clear_q   <= wclr_d;
      bank_q        <= bank_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_write_last;
    state_q == ST_WDATA && rise && cnt_q == 5'h07 && !pins_s.cs_n;
  endsequence

  sequence s_reserved_side;
    fsr_err_set_q && wel_clear_q && !cfg_wr_q ##1 !fsr_err_set_q && !wel_clear_q;
  endsequence

  // Reserved read loads all ones
  AST_RSV_READ: assert property (state_q == ST_RLOAD && fall && !pins_s.cs_n
    && cfg_addr_q > fvsb_pkg::OFS_BANK |=> sout_q == fvsb_pkg::RESERVED_BYTE && dq_oe_q)
    else $error("reserved read not all ones");
  // Reserved write raises both side effects for one cycle
  AST_RSV_WRITE: assert property (s_write_last ##0 cfg_addr_q > fvsb_pkg::OFS_BANK
    |=> s_reserved_side)
    else $error("reserved write side effects wrong");
  // Status byte writes change nothing and flag nothing
  AST_STATUS_WRITE: assert property (s_write_last ##0 cfg_addr_q >= fvsb_pkg::OFS_STATUS
    && cfg_addr_q <= fvsb_pkg::OFS_BANK |=> !cfg_wr_q && !fsr_err_set_q)
    else $error("status byte write had an effect");
  // Config strobe only for the low twelve bytes
  AST_CFG_RANGE: assert property (cfg_wr_q |-> cfg_addr_q <= fvsb_pkg::OFS_CFG_LAST)
    else $error("config write outside config bytes");
  // Bank code follows the operation one edge on
  AST_BANK: assert property (pe_active ##1 pe_active |=> bank_q == {1'b1, $past(pe_bank)})
    else $error("bank code wrong while busy");
  AST_BANK_IDLE: assert property (!pe_active |=> bank_q == 3'h0)
    else $error("bank code not idle");
  // Driver released while deselected
  AST_OE_OFF: assert property (pins_s.cs_n |=> !dq_oe_q)
    else $error("data pin driven while deselected");

endmodule : flash_volatile_status_bytes

// *** tb/link_host_model.sv ***
// Host side serial link model that issues register commands
module link_host_model (
  // Clock
  input  wire logic clk,
  // Link pins
  output logic      cs_n,
  output logic      sck,
  output logic      dq,
  input  wire logic dq_o_q,
  input  wire logic dq_oe_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle link: deselected, clock parked low
  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    dq   = 1'b0;
  end

  // Half a link period, stepping off the clock edge
  task automatic half();
    repeat (4) @(posedge clk);
    #2;
  endtask : half

  // Command, four address bytes, then one write byte or streamed read bytes
  task automatic frame(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] wd,
                       input int nrd, output logic [47:0] rd, output logic oe);
    logic [47:0] sh;
    int          n;
    sh   = {cmd, 24'h5a3c96, a, wd};
    n    = (nrd == 0) ? 48 : 40 + 8 * nrd;
    rd   = '0;
    oe   = 1'b1;
    cs_n = 1'b0;
    half();
    // Shift on the fall; released line toggles so stale bits never match
    for (int i = 0; i < n; i++)
    begin
      dq = (i < 40 || nrd == 0) ? sh[47-i] : ~dq;
      half();
      sck = 1'b1;
      half();
      if (i >= 40 && nrd != 0)
      begin
        rd = {rd[46:0], dq_o_q};
        oe = oe & dq_oe_q;
      end
      sck = 1'b0;
    end
    half();
    cs_n = 1'b1;
    dq   = ~dq;
    half();
  endtask : frame
endmodule : link_host_model

// *** tb/flash_volatile_status_bytes_tb_top.sv ***
// Self-checking bench for the volatile status byte block
module flash_volatile_status_bytes_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0]  WR  = fvsb_pkg::CMD_WR_VOL;
  localparam logic [47:0] RST = 48'h00f0_ffff_fff8;

  logic                  clk = 1'b0;
  logic                  nrst;
  logic                  cs_n_i, sck_i, dq_i, dq_o_q, dq_oe_q;
  logic [95:0]           cfg_bytes;
  logic                  cfg_wr_q, fsr_err_set_q, wel_clear_q;
  logic [7:0]            cfg_addr_q, cfg_data_q, lwa, lwd;
  fvsb_pkg::ecc_events_t ev;
  logic                  octal_ddr, pe_active;
  logic [1:0]            pe_bank;
  int                    num_errors = 0;
  int                    num_checks = 0;
  int                    n_wr = 0;
  int                    n_fsr = 0;
  int                    n_wel = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design and host model
  flash_volatile_status_bytes u_flash_volatile_status_bytes (
    .clk(clk), .nrst(nrst), .cs_n_i(cs_n_i), .sck_i(sck_i), .dq_i(dq_i),
    .dq_o_q(dq_o_q), .dq_oe_q(dq_oe_q), .cfg_bytes(cfg_bytes), .cfg_wr_q(cfg_wr_q),
    .cfg_addr_q(cfg_addr_q), .cfg_data_q(cfg_data_q), .ev(ev), .octal_ddr(octal_ddr),
    .pe_active(pe_active), .pe_bank(pe_bank), .fsr_err_set_q(fsr_err_set_q),
    .wel_clear_q(wel_clear_q)
  );

  link_host_model u_link_host_model (
    .clk(clk), .cs_n(cs_n_i), .sck(sck_i), .dq(dq_i), .dq_o_q(dq_o_q), .dq_oe_q(dq_oe_q)
  );

  // Clock
  always #20 clk = ~clk;

  // Count side effect pulses, keep the last config write
  always @(posedge clk)
  begin
    if (fsr_err_set_q === 1'b1) n_fsr++;
    if (wel_clear_q === 1'b1) n_wel++;
    if (cfg_wr_q === 1'b1) n_wr++;
    if (cfg_wr_q === 1'b1) lwa = cfg_addr_q;
    if (cfg_wr_q === 1'b1) lwd = cfg_data_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic do_reset();
    nrst = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    check(cfg_addr_q, 8'hff);
    check(cfg_data_q, 8'hff);
    check(dq_oe_q, 1'b0);
    nrst = 1'b1;
    repeat (4) @(posedge clk);
    #2;
  endtask : do_reset

  task automatic rd_chk(input logic [7:0] a, input int n, input logic [47:0] exp);
    logic [47:0] rd;
    logic        oe;
    u_link_host_model.frame(fvsb_pkg::CMD_RD_VOL, a, 8'h00, n, rd, oe);
    check(rd, exp);
    check(oe, 1'b1);
  endtask : rd_chk

  task automatic wr_chk(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] d,
                        input int ewr, input int eerr);
    logic [47:0] rd;
    logic        oe;
    int          w0, f0, l0;
    w0 = n_wr;
    f0 = n_fsr;
    l0 = n_wel;
    u_link_host_model.frame(cmd, a, d, 0, rd, oe);
    check(n_wr - w0, ewr);
    check(n_fsr - f0, eerr);
    check(n_wel - l0, eerr);
    if (ewr != 0)
    begin
      check({lwa, lwd}, {a, d});
    end
  endtask : wr_chk

  // One cycle event pulse from the array engine
  task automatic ev_pulse(input logic [4:0] m, input logic [31:0] a);
    @(posedge clk);
    #2;
    ev = fvsb_pkg::ecc_events_t'({m, a});
    @(posedge clk);
    #2;
    ev = '0;
  endtask : ev_pulse

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_map();
    rd_chk(8'h0c, 6, RST);
    rd_chk(8'h12, 1, 48'hff);
    rd_chk(8'hff, 2, 48'hff30);
    rd_chk(8'h0a, 2, 48'h3aff);
    $display("t_map done");
  endtask : t_map

  task automatic t_write();
    wr_chk(WR, 8'h05, 8'ha7, 1, 0);
    wr_chk(WR, 8'h0b, 8'h5e, 1, 0);
    wr_chk(WR, 8'h0c, 8'h11, 0, 0);
    wr_chk(WR, 8'h11, 8'h07, 0, 0);
    wr_chk(WR, 8'h12, 8'h00, 0, 1);
    wr_chk(WR, 8'hff, 8'h00, 0, 1);
    wr_chk(8'h3c, 8'h12, 8'h00, 0, 0);
    rd_chk(8'h0c, 6, RST);
    $display("t_write done");
  endtask : t_write

  task automatic t_flags();
    ev_pulse(5'b11111, 32'hdeadbeef);
    rd_chk(8'h0c, 1, 48'h00);
    cfg_bytes[95:88] = 8'hfe;
    for (int i = 0; i < 14; i++)
      ev_pulse(5'b10000, 32'h00000100);
    rd_chk(8'h0c, 2, 48'h70f0);
    for (int i = 0; i < 3; i++)
      ev_pulse(5'b10000, 32'h00000100);
    ev_pulse(5'b01000, 32'h12345678);
    ev_pulse(5'b01000, 32'hcafe0000);
    octal_ddr = 1'b1;
    ev_pulse(5'b00110, 32'h0);
    ev_pulse(5'b00001, 32'h0);
    rd_chk(8'h0c, 5, 48'hfc70563412);
    octal_ddr = 1'b0;
    cfg_bytes[95:88] = 8'hf6;
    ev_pulse(5'b00110, 32'h0);
    rd_chk(8'h0c, 1, 48'hfc);
    octal_ddr = 1'b1;
    ev_pulse(5'b00100, 32'h0);
    rd_chk(8'h0c, 1, 48'hfe);
    ev_pulse(5'b00010, 32'h0);
    rd_chk(8'h0c, 1, 48'hff);
    $display("t_flags done");
  endtask : t_flags

  task automatic t_single();
    octal_ddr = 1'b0;
    cfg_bytes[95:88] = 8'hfa;
    do_reset();
    rd_chk(8'h0c, 6, RST);
    ev_pulse(5'b01000, 32'h11111111);
    ev_pulse(5'b10000, 32'h89abcdef);
    ev_pulse(5'b10000, 32'h0);
    rd_chk(8'h0c, 5, 48'h14e0cdab89);
    $display("t_single done");
  endtask : t_single

  task automatic t_bank();
    pe_active = 1'b1;
    for (int b = 0; b < 4; b++)
    begin
      pe_bank = b[1:0];
      rd_chk(8'h11, 1, {40'h0, 6'h3f, b[1:0]});
    end
    rd_chk(8'h05, 1, 48'h35);
    pe_active = 1'b0;
    rd_chk(8'h11, 1, 48'hf8);
    $display("t_bank done");
  endtask : t_bank

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    cfg_bytes = 96'hff3a_3938_3736_3534_3332_3130;
    ev = '0;
    octal_ddr = 1'b0;
    pe_active = 1'b0;
    pe_bank = 2'h0;
    lwa = 8'h00;
    lwd = 8'h00;
    do_reset();
    t_map();
    t_write();
    t_flags();
    t_single();
    t_bank();
    tally_and_finish();
  end

  // Watchdog against a hung run
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : flash_volatile_status_bytes_tb_top
